// >>> design/irq_controller.sv
// Six-request prioritised, maskable, vectored interrupt controller
//
// Notes on behaviour
// - Six requests, individual and global enables.
// - Sources: three pins, two timers, low voltage.
// - Pin 2 or receiver drives request zero.
// - Pin 3 shares with transmitter, baud generator.
// - Recovery logic replaces pin 3 when selected.
// - Priority encoder picks among pending requests.
// - Grant clears master enable, core vectors.
// - Flags stay readable while inputs masked.
// - Request two, zero use programmable edges.
// - Request bits 7:6 hold edge select.
// - Six requests form groups A, B, C.
// - Priority bits 4,3,0 order the groups.
// - Priority bits 5,2,1 order within groups.
// - Servicing clears the pending flag.
// - Writing one raises the request.
// - Writing zero clears the request.
// - Request register locked until first enable.
// - Mask bits enable; bit 7 master; reset off.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "irq_params.svh"
module irq_controller (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [7:0]        addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output logic      [7:0]        rdata,
  input  wire logic              port3_pin1,
  input  wire logic              port3_pin2,
  input  wire logic              port3_pin3,
  input  wire logic              uart_rx_event,
  input  wire logic              uart_tx_event,
  input  wire logic              baud_event,
  input  wire logic              timer8_event,
  input  wire logic              timer16_event,
  input  wire logic              low_voltage_event,
  input  wire logic              recovery_event,
  input  wire logic              enable_interrupts_instruction,
  input  wire logic              disable_interrupts,
  input  wire logic              int_ack,
  output logic                   int_req,
  output irq_pkg::irq_id_t       int_vector
);
  import irq_pkg::*;

  // One-hot bit of a request number
  function automatic logic [5:0] onehot(input irq_id_t id);
    return `ONE_HOT_BASE << id;
  endfunction

  // Edge choice: both edges, or rising / falling
  function automatic logic edge_pick(input logic both, input logic rising,
                                     input logic rise, input logic fall);
    return both ? (rise | fall) : (rising ? rise : fall);
  endfunction

  logic [7:0]   source_sel_reg;
  logic [5:0]   priority_reg;
  logic [5:0]   flags_reg;
  logic [5:0]   flags_next;
  logic [1:0]   edge_sel_reg;
  logic [5:0]   mask_reg;
  logic         master_en_reg;
  logic         master_en_next;
  logic         ei_seen_reg;
  logic         pin1_prev_reg;
  logic         pin2_prev_reg;
  logic         pin3_prev_reg;
  logic         grant_valid_reg;
  logic         grant_valid_next;
  irq_id_t      grant_id_reg;
  logic [7:0]   rdata_reg;
  logic [7:0]   rdata_next;

  logic         sel_src;
  logic         sel_prio;
  logic         sel_req;
  logic         sel_mask;
  logic         flag_wr;
  logic         pin1_edge;
  logic         pin2_edge;
  logic         pin3_fall;
  logic         req0_event;
  logic         req1_event;
  req1_src_e    req1_src;
  logic [5:0]   hw_set;
  logic [5:0]   flag_wr_value;
  logic [5:0]   ack_clear;
  logic [5:0]   pending_masked;
  logic         found;
  irq_id_t      winner;
  logic         took_ack;

  // Address decode
  assign sel_src  = (addr == `ADDR_SOURCE_SEL);
  assign sel_prio = (addr == `ADDR_PRIORITY);
  assign sel_req  = (addr == `ADDR_REQUEST);
  assign sel_mask = (addr == `ADDR_MASK);
  // Request register ignores writes until the first enable instruction
  assign flag_wr  = wr_stb && sel_req && ei_seen_reg;

  // Pin edges; pins are synchronous, so one stage of history is enough
  assign pin1_edge = edge_pick(edge_sel_reg == `EDGE_BOTH, edge_sel_reg[1],
                               port3_pin1 & ~pin1_prev_reg,
                               ~port3_pin1 & pin1_prev_reg);
  assign pin2_edge = edge_pick(edge_sel_reg == `EDGE_BOTH, edge_sel_reg[0],
                               port3_pin2 & ~pin2_prev_reg,
                               ~port3_pin2 & pin2_prev_reg);
  assign pin3_fall = ~port3_pin3 & pin3_prev_reg;

  // Request zero: an enabled receiver takes the line away from pin 2
  assign req0_event = source_sel_reg[`SRC_RX_EN_BIT] ? uart_rx_event : pin2_edge;

  // Request one source; recovery logic overrides the serial choices
  assign req1_src =
    (source_sel_reg[`SRC_ANALOG_BIT] || source_sel_reg[`SRC_RECOV_BIT]) ? SRC_RECOVERY :
    source_sel_reg[`SRC_TX_BIT]   ? SRC_TX   :
    source_sel_reg[`SRC_BAUD_BIT] ? SRC_BAUD : SRC_PIN3;
  assign req1_event = (req1_src == SRC_RECOVERY) ? recovery_event :
                      (req1_src == SRC_TX)       ? uart_tx_event :
                      (req1_src == SRC_BAUD)     ? baud_event : pin3_fall;

  // Hardware set vector, independent of the mask so polling sees it
  assign hw_set = {timer16_event, timer8_event, low_voltage_event,
                   pin1_edge, req1_event, req0_event};

  // Flag update: a write replaces, service clears, hardware set wins last
  assign ack_clear     = (int_ack && grant_valid_reg) ? onehot(grant_id_reg) : `RST_FLAGS;
  assign flag_wr_value = wdata[`REQ_FLAG_HI:0] | hw_set;
  assign flags_next    = flag_wr ? flag_wr_value : ((flags_reg & ~ack_clear) | hw_set);
  assign took_ack      = int_ack && grant_valid_reg;

  // Master enable: set by the enable instruction, dropped by a grant
  assign master_en_next =
    (took_ack || disable_interrupts) ? 1'b0 :
    (wr_stb && sel_mask && !wdata[`MASK_MASTER_BIT]) ? 1'b0 :
    enable_interrupts_instruction ? 1'b1 : master_en_reg;

  // Priority resolution on masked flags only; flags stay visible to reads
  assign pending_masked = flags_reg & mask_reg;
  irq_priority_pick u_pick (
    .pending      (pending_masked),
    .priority_sel (priority_reg),
    .found        (found),
    .winner       (winner)
  );
  // Registered grant; a taken acknowledge drops it at once
  assign grant_valid_next = master_en_reg && found && !took_ack;

  // Read mux; unmapped addresses and idle cycles read as zero
  assign rdata_next =
    !rd_stb  ? `RST_BYTE :
    sel_src  ? source_sel_reg :
    sel_prio ? {2'b00, priority_reg} :
    sel_req  ? {edge_sel_reg, flags_reg} :
    sel_mask ? {master_en_reg, 1'b0, mask_reg} : `RST_BYTE;

  // Configuration registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      source_sel_reg <= `RST_BYTE;
      priority_reg   <= `RST_PRIO;
      mask_reg       <= `RST_FLAGS;
      edge_sel_reg   <= `RST_EDGE;
    end else begin
      if (wr_stb && sel_src) begin
        source_sel_reg <= wdata;
      end
      if (wr_stb && sel_prio) begin
        priority_reg <= wdata[`IPR_USED_HI:0];
      end
      if (wr_stb && sel_mask) begin
        mask_reg <= wdata[`REQ_FLAG_HI:0];
      end
      if (flag_wr) begin
        edge_sel_reg <= wdata[`REQ_EDGE_HI:`REQ_EDGE_LO];
      end
    end
  end

  // Flags, enables and pin history
  always_ff @(posedge mclk) begin
    if (rst) begin
      flags_reg     <= `RST_FLAGS;
      master_en_reg <= 1'b0;
      ei_seen_reg   <= 1'b0;
      pin1_prev_reg <= 1'b0;
      pin2_prev_reg <= 1'b0;
      pin3_prev_reg <= 1'b0;
    end else begin
      flags_reg     <= flags_next;
      master_en_reg <= master_en_next;
      ei_seen_reg   <= ei_seen_reg | enable_interrupts_instruction;
      pin1_prev_reg <= port3_pin1;
      pin2_prev_reg <= port3_pin2;
      pin3_prev_reg <= port3_pin3;
    end
  end

  // Grant and read data; the core does the vector fetch and context save
  always_ff @(posedge mclk) begin
    if (rst) begin
      grant_valid_reg <= 1'b0;
      grant_id_reg    <= `RST_ID;
      rdata_reg       <= `RST_BYTE;
    end else begin
      grant_valid_reg <= grant_valid_next;
      grant_id_reg    <= winner;
      rdata_reg       <= rdata_next;
    end
  end

  assign int_req    = grant_valid_reg;
  assign int_vector = grant_id_reg;
  assign rdata      = rdata_reg;

  // Checks on the controller's own behaviour
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_taken;
    int_req && int_ack && !enable_interrupts_instruction;
  endsequence

  sequence s_quiet;
    !int_req [*2];
  endsequence

  property p_grant_closes;
    s_taken |=> !master_en_reg ##0 s_quiet;
  endproperty

  a_grant_closes_master: assert property (p_grant_closes)
    else $error("grant did not close master enable");

  a_ack_clears_flag: assert property (
    (took_ack && !flag_wr && ((hw_set & ack_clear) == `RST_FLAGS))
    |=> ((flags_reg & $past(ack_clear)) == `RST_FLAGS))
    else $error("serviced flag not cleared");

  a_req_needs_enables: assert property (
    int_req |-> ($past(master_en_reg) && ($past(pending_masked) & onehot(int_vector)) != 0))
    else $error("request raised without enables");

  a_write_lock_flags: assert property (
    (wr_stb && sel_req && !ei_seen_reg && hw_set == `RST_FLAGS && !took_ack)
    |=> ($stable(flags_reg) && $stable(edge_sel_reg)))
    else $error("request register changed before enable");

  a_write_flag_value: assert property (
    flag_wr |=> (flags_reg == $past(flag_wr_value)))
    else $error("written flag value not taken");

  a_hw_sets_flag: assert property (
    (hw_set != `RST_FLAGS) |=> ((flags_reg & $past(hw_set)) == $past(hw_set)))
    else $error("hardware event lost");

  a_rx_owns_zero: assert property (
    source_sel_reg[`SRC_RX_EN_BIT] |-> (hw_set[`REQ_ID_0] == uart_rx_event))
    else $error("request zero not from receiver");

  a_tx_owns_one: assert property (
    (req1_src != SRC_RECOVERY && source_sel_reg[`SRC_TX_BIT])
    |-> (hw_set[`REQ_ID_1] == uart_tx_event))
    else $error("request one not from transmitter");

  a_recovery_owns_one: assert property (
    (source_sel_reg[`SRC_ANALOG_BIT] || source_sel_reg[`SRC_RECOV_BIT])
    |-> (hw_set[`REQ_ID_1] == recovery_event))
    else $error("request one not from recovery logic");

  a_order_example: assert property (
    (master_en_reg && pending_masked == 6'h23 && priority_reg == 6'h01 && !took_ack)
    |=> (int_req && int_vector == `REQ_ID_1))
    else $error("group order example violated");

  a_read_polled_flags: assert property (
    (rd_stb && sel_req) |=> (rdata == {$past(edge_sel_reg), $past(flags_reg)}))
    else $error("polled flags read wrong");

  a_reset_disabled: assert property (
    $fell(rst) |-> (mask_reg == `RST_FLAGS && !master_en_reg && !int_req))
    else $error("interrupts enabled after reset");

  // The core's disable pulse must shut the master enable at once
  a_disable_closes: assert property (
    disable_interrupts |=> !master_en_reg)
    else $error("disable pulse left master enable on");

  // A closed master enable withdraws the request one cycle later
  a_master_gates_req: assert property (
    !master_en_reg |=> !int_req)
    else $error("request raised with master enable off");

  // Individual enables are taken whole from the written byte
  a_mask_write_taken: assert property (
    (wr_stb && sel_mask) |=> (mask_reg == $past(wdata[`REQ_FLAG_HI:0])))
    else $error("mask write not taken");

  // Written zeros clear unless hardware sets the same bit that cycle
  a_write_zero_clears: assert property (
    flag_wr |=> ((flags_reg & ~$past(wdata[`REQ_FLAG_HI:0]) & ~$past(hw_set)) == `RST_FLAGS))
    else $error("written zero did not clear flag");

  // Edge select bits follow an unlocked request register write
  a_edge_bits_write: assert property (
    flag_wr |=> (edge_sel_reg == $past(wdata[`REQ_EDGE_HI:`REQ_EDGE_LO])))
    else $error("edge select bits not written");

  // The two reserved order codes must never grant anything
  a_reserved_order_idle: assert property (
    (priority_reg[`IPR_ORDER_HI] == priority_reg[`IPR_ORDER_MID] &&
     priority_reg[`IPR_ORDER_MID] == priority_reg[`IPR_ORDER_LO]) |-> !found)
    else $error("reserved priority order granted");

  // Read data return to zero outside the answer cycle
  a_rdata_idle_zero: assert property (
    !rd_stb |=> (rdata == `RST_BYTE))
    else $error("read data not idle");

  // Pin 3 requests on its falling edge only; a rise is no event
  a_pin3_rise_quiet: assert property (
    (req1_src == SRC_PIN3 && port3_pin3 && !pin3_prev_reg) |-> !hw_set[`REQ_ID_1])
    else $error("pin 3 rising edge raised request");
endmodule

// >>> design/irq_params.svh
// Register map, field positions and reset values of the interrupt controller
`ifndef IRQ_PARAMS_SVH
`define IRQ_PARAMS_SVH

// Register addresses
`define ADDR_SOURCE_SEL 8'hF7
`define ADDR_PRIORITY   8'hF9
`define ADDR_REQUEST    8'hFA
`define ADDR_MASK       8'hFB

// Source select register fields
`define SRC_RX_EN_BIT   0
`define SRC_ANALOG_BIT  1
`define SRC_RECOV_BIT   4
`define SRC_BAUD_BIT    5
`define SRC_TX_BIT      7

// Request register fields
`define REQ_EDGE_HI     7
`define REQ_EDGE_LO     6
`define REQ_FLAG_HI     5

// Mask register field
`define MASK_MASTER_BIT 7

// Priority register fields
`define IPR_ORDER_HI    4
`define IPR_ORDER_MID   3
`define IPR_ORDER_LO    0
`define IPR_SWAP_A      5
`define IPR_SWAP_B      2
`define IPR_SWAP_C      1
`define IPR_USED_HI     5

// Request numbers
`define REQ_ID_0        3'h0
`define REQ_ID_1        3'h1
`define REQ_ID_2        3'h2
`define REQ_ID_3        3'h3
`define REQ_ID_4        3'h4
`define REQ_ID_5        3'h5

// Reset values and other constants
`define RST_BYTE        8'h00
`define RST_FLAGS       6'h00
`define RST_EDGE        2'h0
`define RST_PRIO        6'h00
`define RST_ID          3'h0
`define EDGE_BOTH       2'h3
`define ONE_HOT_BASE    6'h01

`endif

// >>> design/irq_pkg.sv
// Types shared by the interrupt controller modules
package irq_pkg;
  typedef logic [2:0] irq_id_t;

  typedef enum logic [2:0] {
    ORD_OFF0 = 3'b000,
    ORD_CBA  = 3'b001,
    ORD_ABC  = 3'b010,
    ORD_ACB  = 3'b011,
    ORD_BCA  = 3'b100,
    ORD_CAB  = 3'b101,
    ORD_BAC  = 3'b110,
    ORD_OFF7 = 3'b111
  } group_order_e;

  typedef enum logic [1:0] {
    SRC_PIN3     = 2'b00,
    SRC_TX       = 2'b01,
    SRC_BAUD     = 2'b10,
    SRC_RECOVERY = 2'b11
  } req1_src_e;
endpackage

// >>> design/irq_priority_pick.sv
// Grouped programmable priority encoder for the six requests
`timescale 1ns/1ps
`include "irq_params.svh"
module irq_priority_pick (
  input  wire logic [5:0]     pending,
  input  wire logic [5:0]     priority_sel,
  output logic                found,
  output irq_pkg::irq_id_t    winner
);
  import irq_pkg::*;

  // Pick inside one group; result is {valid, id}
  function automatic logic [3:0] pick_in_group(input logic    first_pend,
                                               input logic    second_pend,
                                               input logic    swap,
                                               input irq_id_t first_id,
                                               input irq_id_t second_id);
    logic [3:0] res;
    res = 4'h0;
    if (!swap && first_pend) begin
      res = {1'b1, first_id};
    end else if (second_pend) begin
      res = {1'b1, second_id};
    end else if (first_pend) begin
      res = {1'b1, first_id};
    end
    return res;
  endfunction

  // First valid of three candidates in the given order
  function automatic logic [3:0] first_of(input logic [3:0] x,
                                          input logic [3:0] y,
                                          input logic [3:0] z);
    logic [3:0] res;
    res = 4'h0;
    if (x[3]) begin
      res = x;
    end else if (y[3]) begin
      res = y;
    end else if (z[3]) begin
      res = z;
    end
    return res;
  endfunction

  logic [3:0]   grp_a;
  logic [3:0]   grp_b;
  logic [3:0]   grp_c;
  group_order_e order;
  logic [3:0]   chosen;

  // Three groups of two: A = 5/3, B = 2/0, C = 1/4
  assign grp_a = pick_in_group(pending[`REQ_ID_5], pending[`REQ_ID_3],
                               priority_sel[`IPR_SWAP_A], `REQ_ID_5, `REQ_ID_3);
  assign grp_b = pick_in_group(pending[`REQ_ID_2], pending[`REQ_ID_0],
                               priority_sel[`IPR_SWAP_B], `REQ_ID_2, `REQ_ID_0);
  assign grp_c = pick_in_group(pending[`REQ_ID_1], pending[`REQ_ID_4],
                               priority_sel[`IPR_SWAP_C], `REQ_ID_1, `REQ_ID_4);
  assign order = group_order_e'({priority_sel[`IPR_ORDER_HI], priority_sel[`IPR_ORDER_MID],
                                 priority_sel[`IPR_ORDER_LO]});

  // Group ordering; the two reserved codes grant nothing
  assign chosen = (order == ORD_CBA) ? first_of(grp_c, grp_b, grp_a) :
                  (order == ORD_ABC) ? first_of(grp_a, grp_b, grp_c) :
                  (order == ORD_ACB) ? first_of(grp_a, grp_c, grp_b) :
                  (order == ORD_BCA) ? first_of(grp_b, grp_c, grp_a) :
                  (order == ORD_CAB) ? first_of(grp_c, grp_a, grp_b) :
                  (order == ORD_BAC) ? first_of(grp_b, grp_a, grp_c) : 4'h0;
  assign found  = chosen[3];
  assign winner = chosen[2:0];
endmodule

// >>> verification/core_model.sv
// Behavioural processor core that takes granted interrupt requests
`timescale 1ns/1ps
module core_model
  import irq_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             ack_on,
  input  wire logic [3:0]       ack_wait,
  input  wire logic             int_req,
  input  wire irq_pkg::irq_id_t int_vector,
  output logic                  int_ack,
  output logic [7:0]            ack_cnt,
  output irq_pkg::irq_id_t      last_vec
);
  logic [3:0] wait_reg;

  // Ack after a chosen wait, so both prompt and slow cores are seen
  always_ff @(posedge mclk) begin
    if (rst) begin
      int_ack <= 1'b0;
      wait_reg <= 4'h0;
      ack_cnt <= 8'h00;
      last_vec <= 3'h0;
    end else begin
      int_ack <= 1'b0;
      if (int_ack && int_req) begin
        // The vector index taken here selects the core's 16-bit fetch
        ack_cnt <= ack_cnt + 8'h01;
        last_vec <= int_vector;
        wait_reg <= 4'h0;
      end else if (ack_on && int_req && !int_ack) begin
        // Ack only while a request stands; a dropped request is never acked
        if (wait_reg >= ack_wait) int_ack <= 1'b1;
        else wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
module testbench;
  import irq_pkg::*;
  logic            mclk = 1'b0;
  logic            rst = 1'b1;
  logic [7:0]      addr = 8'h00;
  logic [7:0]      wdata = 8'h00;
  logic            wr_stb = 1'b0;
  logic            rd_stb = 1'b0;
  logic [7:0]      rdata;
  logic [9:0]      stim = 10'h000;
  logic            ei = 1'b0;
  logic            dis = 1'b0;
  logic            int_ack;
  logic            int_req;
  irq_id_t         int_vector;
  logic            ack_on = 1'b0;
  logic [3:0]      ack_wait = 4'h0;
  logic [7:0]      ack_cnt;
  irq_id_t         last_vec;
  int              n_fail = 0;
  int              n_tests = 0;
  // Source table: select byte, stimulus bit, expected flags
  localparam logic [7:0] src_f7 [15] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h80, 8'h20, 8'hA0,
    8'h10, 8'h02, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam int         src_k [15] = '{0, 0, 7, 7, 1, 2, 2, 6, 6, 8, 8, 3, 4, 5, 9};
  localparam logic [7:0] src_x [15] = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h02, 8'h02, 8'h00,
    8'h02, 8'h02, 8'h02, 8'h00, 8'h10, 8'h20, 8'h08, 8'h04};

  // Clock at 250 MHz
  always #2 mclk = ~mclk;

  irq_controller dut (
    .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .port3_pin1(stim[9]), .port3_pin2(stim[7]), .port3_pin3(stim[8]),
    .uart_rx_event(stim[0]), .uart_tx_event(stim[1]), .baud_event(stim[2]),
    .timer8_event(stim[3]), .timer16_event(stim[4]), .low_voltage_event(stim[5]),
    .recovery_event(stim[6]), .enable_interrupts_instruction(ei),
    .disable_interrupts(dis), .int_ack(int_ack), .int_req(int_req),
    .int_vector(int_vector));

  core_model core (.mclk(mclk), .rst(rst), .ack_on(ack_on), .ack_wait(ack_wait),
    .int_req(int_req), .int_vector(int_vector), .int_ack(int_ack), .ack_cnt(ack_cnt),
    .last_vec(last_vec));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(what, d, exp);
  endtask

  task automatic pulse(input logic is_ei);
    @(posedge mclk);
    if (is_ei) ei <= 1'b1;
    else dis <= 1'b1;
    @(posedge mclk);
    ei <= 1'b0;
    dis <= 1'b0;
  endtask

  // Settle three cycles so the flag lands before the next read
  task automatic lvl(input logic [9:0] v);
    @(posedge mclk);
    stim <= v;
    repeat (3) @(posedge mclk);
  endtask

  task automatic test_reset;
    rd_chk("source", 8'hF7, 8'h00);
    rd_chk("priority", 8'hF9, 8'h00);
    rd_chk("request", 8'hFA, 8'h00);
    rd_chk("mask", 8'hFB, 8'h00);
    wr(8'hFA, 8'hFF);
    rd_chk("locked request", 8'hFA, 8'h00);
    wr(8'hF9, 8'hFF);
    rd_chk("priority bits", 8'hF9, 8'h3F);
    wr(8'hF7, 8'hB3);
    rd_chk("source bits", 8'hF7, 8'hB3);
    rd_chk("unmapped", 8'h10, 8'h00);
    $display("test_reset done");
  endtask

  task automatic test_flags;
    wr(8'hFB, 8'h00);
    pulse(1'b1);
    rd_chk("master on", 8'hFB, 8'h80);
    wr(8'hFA, 8'h3F);
    rd_chk("soft raise", 8'hFA, 8'h3F);
    check("masked req", {7'h00, int_req}, 8'h00);
    wr(8'hFA, 8'h05);
    rd_chk("soft clear", 8'hFA, 8'h05);
    pulse(1'b0);
    rd_chk("master off", 8'hFB, 8'h00);
    $display("test_flags done");
  endtask

  // Each source reaches its flag with the mask shut, as polling sees it
  task automatic test_sources;
    logic [7:0] d;
    for (int i = 0; i < 15; i++) begin
      wr(8'hF7, src_f7[i]);
      wr(8'hFA, 8'h00);
      lvl(10'(10'h001 << src_k[i]));
      lvl(10'h000);
      rd(8'hFA, d);
      check("source flags", d, src_x[i]);
    end
    check("polled req", {7'h00, int_req}, 8'h00);
    $display("test_sources done");
  endtask

  task automatic test_edges;
    wr(8'hF7, 8'h00);
    wr(8'hFA, 8'h80);
    lvl(10'h200);
    rd_chk("pin1 rise", 8'hFA, 8'h84);
    wr(8'hFA, 8'h80);
    lvl(10'h000);
    rd_chk("pin1 fall ignored", 8'hFA, 8'h80);
    wr(8'hFA, 8'hC0);
    lvl(10'h080);
    rd_chk("pin2 both rise", 8'hFA, 8'hC1);
    wr(8'hFA, 8'hC0);
    lvl(10'h000);
    rd_chk("pin2 both fall", 8'hFA, 8'hC1);
    $display("test_edges done");
  endtask

  // Grant through the core, then look at vector, flags and master
  task automatic prio_case(input logic [7:0] m, input logic [7:0] p, input logic [7:0] f,
                           input irq_id_t e, input logic [3:0] w);
    logic [7:0] c0;
    wr(8'hFB, m);
    wr(8'hF9, p);
    wr(8'hFA, f);
    c0 = ack_cnt;
    ack_wait <= w;
    ack_on <= 1'b1;
    pulse(1'b1);
    for (int i = 0; i < 40 && ack_cnt === c0; i++) @(posedge mclk);
    ack_on <= 1'b0;
    check("vector", {5'h00, last_vec}, {5'h00, e});
    rd_chk("serviced", 8'hFA, f & ~(8'h01 << e));
    rd_chk("master cleared", 8'hFB, m);
  endtask

  task automatic test_priority;
    prio_case(8'h3F, 8'h01, 8'h23, 3'h1, 4'h0);
    prio_case(8'h3F, 8'h01, 8'h21, 3'h0, 4'h9);
    prio_case(8'h3F, 8'h01, 8'h20, 3'h5, 4'h2);
    prio_case(8'h3F, 8'h01, 8'h05, 3'h2, 4'h0);
    prio_case(8'h3F, 8'h05, 8'h05, 3'h0, 4'h0);
    prio_case(8'h3F, 8'h08, 8'h18, 3'h3, 4'h0);
    prio_case(8'h3F, 8'h08, 8'h28, 3'h5, 4'h0);
    prio_case(8'h3F, 8'h28, 8'h28, 3'h3, 4'h0);
    prio_case(8'h3F, 8'h03, 8'h12, 3'h4, 4'h0);
    prio_case(8'h1F, 8'h01, 8'h30, 3'h4, 4'h0);
    prio_case(8'h3F, 8'h10, 8'h22, 3'h1, 4'h0);
    prio_case(8'h3F, 8'h18, 8'h30, 3'h5, 4'h0);
    prio_case(8'h3F, 8'h11, 8'h30, 3'h4, 4'h0);
    prio_case(8'h3F, 8'h09, 8'h12, 3'h1, 4'h0);
    $display("test_priority done");
  endtask

  // Master off and a reserved order both keep the request back
  task automatic test_refuse;
    wr(8'hFB, 8'h3F);
    wr(8'hF9, 8'h01);
    wr(8'hFA, 8'h01);
    repeat (10) @(posedge mclk);
    check("master off req", {7'h00, int_req}, 8'h00);
    wr(8'hF9, 8'h00);
    pulse(1'b1);
    repeat (10) @(posedge mclk);
    check("order off req", {7'h00, int_req}, 8'h00);
    $display("test_refuse done");
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    test_reset;
    test_flags;
    test_sources;
    test_edges;
    test_priority;
    test_refuse;
    give_verdict;
  end

  // Watchdog well beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    give_verdict;
  end
endmodule
